// *** src/fbs_pkg.sv ***
package fbs_pkg;

  localparam int WORD_W = 16;
  localparam int NODE_W = 8;
  localparam int CNT_W = 8;

  // operation codes of a transaction
  localparam logic [15:0] OP_WRITE = 16'h0001;
  localparam logic [15:0] OP_READ = 16'h0002;
  localparam logic [15:0] OP_GWRITE = 16'h0005;
  localparam logic [15:0] OP_GREAD = 16'h0006;

  // command register window
  localparam logic [15:0] CMD_LO = 16'h0001;
  localparam logic [15:0] CMD_HI = 16'h000f;
  localparam int CMD_IDX_W = 4;
  localparam int CMD_FIRST = 1;
  localparam int CMD_LAST = 15;
  localparam logic [15:0] CODE_RUN_CMD = 16'h0001;
  localparam logic [15:0] CODE_FREQ_REF = 16'h0002;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // parameter register ranges
  localparam int PARAM_RANGES = 9;
  localparam logic [15:0] PARAM_LO [PARAM_RANGES] = '{
    16'h0100, 16'h018d, 16'h0200, 16'h0280, 16'h0300,
    16'h0380, 16'h0400, 16'h0480, 16'h0500};
  localparam logic [15:0] PARAM_HI [PARAM_RANGES] = '{
    16'h0125, 16'h01a5, 16'h0240, 16'h0296, 16'h0316,
    16'h039c, 16'h0420, 16'h04aa, 16'h050d};

  // monitor register ranges
  localparam int MON_RANGES = 3;
  localparam logic [15:0] MON_LO [MON_RANGES] = '{
    16'h0020, 16'hf000, 16'hf100};
  localparam logic [15:0] MON_HI [MON_RANGES] = '{
    16'h0097, 16'hf00f, 16'hf10a};

  // special registers
  localparam logic [15:0] CODE_BCAST_SRC = 16'hf200;
  localparam logic [15:0] CODE_FREQ_MULT = 16'hf201;
  localparam logic [15:0] CODE_ACTIVATE = 16'hffdd;
  localparam logic [15:0] CODE_SAVE = 16'hfffd;
  localparam logic [15:0] CMD_TRIGGER_VAL = 16'h0000;
  localparam logic [15:0] SPECIAL_RD_VAL = 16'h0000;

  // broadcast source node
  localparam logic [15:0] BCAST_SRC_RESET = 16'h0000;
  localparam logic [15:0] BCAST_OFF = 16'h0000;
  localparam logic [15:0] NODE_MAX = 16'h0040;

  // broadcast selector word and frame lengths
  localparam logic [15:0] SEL_RUN = 16'h0001;
  localparam logic [15:0] SEL_FREQ = 16'h0002;
  localparam logic [15:0] SEL_BOTH = 16'h0003;
  localparam logic [7:0] GW_LEN_ONE = 8'h02;
  localparam logic [7:0] GW_LEN_BOTH = 8'h03;

  // global status image
  localparam int GREAD_WORDS = 8;
  localparam int GR_IDX_W = 3;
  localparam logic [2:0] GR_IDX_LAST = 3'h7;

  typedef enum {
    FBS_CLS_NONE,
    FBS_CLS_CMD,
    FBS_CLS_PARAM,
    FBS_CLS_MON,
    FBS_CLS_SPECIAL
  } fbs_class_t;

endpackage

// *** src/fbs_code_class.sv ***
`timescale 1ns/100ps
module fbs_code_class (
  input wire logic [15:0] code,
  output fbs_pkg::fbs_class_t cls
);

  logic [fbs_pkg::PARAM_RANGES-1:0] param_hit;
  logic [fbs_pkg::MON_RANGES-1:0] mon_hit;
  logic cmd_hit;
  logic special_hit;

  genvar gi;
  generate
    for (gi = 0; gi < fbs_pkg::PARAM_RANGES; gi++) begin : g_param
      assign param_hit[gi] = (code >= fbs_pkg::PARAM_LO[gi]) &&
                             (code <= fbs_pkg::PARAM_HI[gi]);
    end
    for (gi = 0; gi < fbs_pkg::MON_RANGES; gi++) begin : g_mon
      assign mon_hit[gi] = (code >= fbs_pkg::MON_LO[gi]) &&
                           (code <= fbs_pkg::MON_HI[gi]);
    end
  endgenerate

  assign cmd_hit = (code >= fbs_pkg::CMD_LO) && (code <= fbs_pkg::CMD_HI);
  assign special_hit = (code == fbs_pkg::CODE_BCAST_SRC) ||
                       (code == fbs_pkg::CODE_FREQ_MULT) ||
                       (code == fbs_pkg::CODE_ACTIVATE) ||
                       (code == fbs_pkg::CODE_SAVE);

  always_comb begin
    if (cmd_hit) begin
      cls = fbs_pkg::FBS_CLS_CMD;
    end else if (|param_hit) begin
      cls = fbs_pkg::FBS_CLS_PARAM;
    end else if (|mon_hit) begin
      cls = fbs_pkg::FBS_CLS_MON;
    end else if (special_hit) begin
      cls = fbs_pkg::FBS_CLS_SPECIAL;
    end else begin
      cls = fbs_pkg::FBS_CLS_NONE;
    end
  end

endmodule // fbs_code_class

// *** src/fbs_slave.sv ***
// Functional notes
// - All drive data is 16-bit holding registers named by data code.
// - Command, parameter, special are read/write; monitor is read only.
// - Parameter writes stay inactive until activate; save also commits.
// - Opcode 1 writes command, parameter or special registers of one node.
// - Opcode 2 reads any register class of one node.
// - Opcode 5 broadcasts two or three words, taken in at once.
// - Selector 3: run and frequency; 1: run only; 2: frequency only.
// - Drive not set up for broadcast discards every broadcast frame.
// - Broadcast taken only from node in source register; zero disables.
// - Opcode 6 returns eight status words to any controller.
// - Global status read answered only while global read switch is on.
// - Image: run, freq, current, bus volts, status, faults one to three.
`timescale 1ns/100ps
module fbs_slave (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [15:0] req_op,
  input wire logic [7:0] req_src,
  input wire logic [15:0] req_code,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_count,
  input wire logic [15:0] req_gw1,
  input wire logic [15:0] req_gw2,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic rsp_last,
  output logic [15:0] rsp_data,
  output logic [15:0] run_cmd,
  output logic [15:0] freq_ref,
  output logic [15:0] broadcast_source_node,
  output logic param_wr_valid,
  output logic [15:0] param_wr_code,
  output logic [15:0] param_wr_data,
  output logic params_pending,
  output logic activate_pulse,
  output logic save_pulse,
  output logic [15:0] core_rd_code,
  input wire logic [15:0] core_rd_data,
  input wire logic global_read_switch,
  input wire logic [15:0] mon_out_freq,
  input wire logic [15:0] mon_out_current,
  input wire logic [15:0] mon_bus_volt,
  input wire logic [15:0] mon_drive_status,
  input wire logic [15:0] mon_fault1,
  input wire logic [15:0] mon_fault2,
  input wire logic [15:0] mon_fault3
);

  typedef enum {
    FBS_IDLE,
    FBS_RD_WAIT,
    FBS_GREAD
  } fbs_state_t;

  fbs_state_t state;
  fbs_state_t next_state;
  fbs_pkg::fbs_class_t cls;
  logic [15:0] cmd_reg [fbs_pkg::CMD_FIRST:fbs_pkg::CMD_LAST];
  logic [15:0] gr_word [fbs_pkg::GREAD_WORDS];
  logic [fbs_pkg::GR_IDX_W-1:0] gr_idx;
  logic [fbs_pkg::CMD_IDX_W-1:0] cmd_idx;
  logic take;
  logic is_write;
  logic is_read;
  logic is_gwrite;
  logic is_gread;
  logic special_ok;
  logic wr_ok;
  logic gw_src_ok;
  logic gw_frame_ok;
  logic gw_ok;
  logic gread_ok;
  logic slow_read;

  fbs_code_class u_class (
    .code(req_code),
    .cls(cls)
  );

  assign take = req_valid && req_ready;
  assign is_write = take && (req_op == fbs_pkg::OP_WRITE);
  assign is_read = take && (req_op == fbs_pkg::OP_READ);
  assign is_gwrite = take && (req_op == fbs_pkg::OP_GWRITE);
  assign is_gread = take && (req_op == fbs_pkg::OP_GREAD);
  assign cmd_idx = req_code[fbs_pkg::CMD_IDX_W-1:0];

  // source register only takes a node address or the disable value
  assign special_ok = (req_code != fbs_pkg::CODE_BCAST_SRC) ||
                      (req_wdata <= fbs_pkg::NODE_MAX);

  // monitor and unmapped codes refuse writes
  assign wr_ok = is_write &&
                 ((cls == fbs_pkg::FBS_CLS_CMD) ||
                  (cls == fbs_pkg::FBS_CLS_PARAM) ||
                  ((cls == fbs_pkg::FBS_CLS_SPECIAL) && special_ok));

  assign gw_src_ok = (broadcast_source_node != fbs_pkg::BCAST_OFF) &&
                     ({8'h00, req_src} == broadcast_source_node);
  assign gw_frame_ok =
    ((req_wdata == fbs_pkg::SEL_BOTH) &&
     (req_count == fbs_pkg::GW_LEN_BOTH)) ||
    (((req_wdata == fbs_pkg::SEL_RUN) || (req_wdata == fbs_pkg::SEL_FREQ)) &&
     (req_count >= fbs_pkg::GW_LEN_ONE));
  assign gw_ok = is_gwrite && gw_src_ok && gw_frame_ok;

  assign gread_ok = is_gread && global_read_switch;
  assign slow_read = is_read && ((cls == fbs_pkg::FBS_CLS_PARAM) ||
                                 (cls == fbs_pkg::FBS_CLS_MON));

  // status image in transfer order
  assign gr_word[0] = cmd_reg[fbs_pkg::CMD_FIRST];
  assign gr_word[1] = mon_out_freq;
  assign gr_word[2] = mon_out_current;
  assign gr_word[3] = mon_bus_volt;
  assign gr_word[4] = mon_drive_status;
  assign gr_word[5] = mon_fault1;
  assign gr_word[6] = mon_fault2;
  assign gr_word[7] = mon_fault3;

  always_comb begin
    next_state = state;
    case (state)
      FBS_IDLE: begin
        if (slow_read) begin
          next_state = FBS_RD_WAIT;
        end else if (gread_ok) begin
          next_state = FBS_GREAD;
        end
      end
      FBS_RD_WAIT: begin
        next_state = FBS_IDLE;
      end
      FBS_GREAD: begin
        if (gr_idx == fbs_pkg::GR_IDX_LAST) begin
          next_state = FBS_IDLE;
        end
      end
      default: begin
        next_state = FBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FBS_IDLE;
      req_ready <= 1'b0;
    end else begin
      state <= next_state;
      req_ready <= (next_state == FBS_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gr_idx <= '0;
    end else if (state == FBS_GREAD) begin
      gr_idx <= gr_idx + 1'b1;
    end else begin
      gr_idx <= '0;
    end
  end

  // command registers, written singly or by broadcast
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = fbs_pkg::CMD_FIRST; i <= fbs_pkg::CMD_LAST; i++) begin
        cmd_reg[i] <= fbs_pkg::CMD_RESET;
      end
    end else if (wr_ok && (cls == fbs_pkg::FBS_CLS_CMD)) begin
      cmd_reg[cmd_idx] <= req_wdata;
    end else if (gw_ok) begin
      case (req_wdata)
        fbs_pkg::SEL_BOTH: begin
          cmd_reg[fbs_pkg::CMD_FIRST] <= req_gw1;
          cmd_reg[fbs_pkg::CMD_FIRST+1] <= req_gw2;
        end
        fbs_pkg::SEL_RUN: begin
          cmd_reg[fbs_pkg::CMD_FIRST] <= req_gw1;
        end
        fbs_pkg::SEL_FREQ: begin
          cmd_reg[fbs_pkg::CMD_FIRST+1] <= req_gw1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_cmd <= fbs_pkg::CMD_RESET;
      freq_ref <= fbs_pkg::CMD_RESET;
    end else begin
      run_cmd <= cmd_reg[fbs_pkg::CMD_FIRST];
      freq_ref <= cmd_reg[fbs_pkg::CMD_FIRST+1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      broadcast_source_node <= fbs_pkg::BCAST_SRC_RESET;
    end else if (wr_ok && (req_code == fbs_pkg::CODE_BCAST_SRC)) begin
      broadcast_source_node <= req_wdata;
    end
  end

  // parameter writes go to the core inactive until activate or save
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      param_wr_valid <= 1'b0;
      param_wr_code <= fbs_pkg::CMD_RESET;
      param_wr_data <= fbs_pkg::CMD_RESET;
    end else begin
      param_wr_valid <= wr_ok && (cls == fbs_pkg::FBS_CLS_PARAM);
      if (wr_ok && (cls == fbs_pkg::FBS_CLS_PARAM)) begin
        param_wr_code <= req_code;
        param_wr_data <= req_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      params_pending <= 1'b0;
      activate_pulse <= 1'b0;
      save_pulse <= 1'b0;
    end else begin
      activate_pulse <= 1'b0;
      save_pulse <= 1'b0;
      if (wr_ok && (cls == fbs_pkg::FBS_CLS_PARAM)) begin
        params_pending <= 1'b1;
      end else if (wr_ok && (req_wdata == fbs_pkg::CMD_TRIGGER_VAL) &&
                   (req_code == fbs_pkg::CODE_ACTIVATE)) begin
        params_pending <= 1'b0;
        activate_pulse <= 1'b1;
      end else if (wr_ok && (req_wdata == fbs_pkg::CMD_TRIGGER_VAL) &&
                   (req_code == fbs_pkg::CODE_SAVE)) begin
        params_pending <= 1'b0;
        activate_pulse <= 1'b1;
        save_pulse <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_rd_code <= fbs_pkg::CMD_RESET;
    end else if (slow_read) begin
      core_rd_code <= req_code;
    end
  end

  // answers: writes and fast reads next cycle, core reads one later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_last <= 1'b0;
      rsp_data <= fbs_pkg::CMD_RESET;
    end else begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_last <= 1'b0;
      rsp_data <= fbs_pkg::CMD_RESET;
      case (state)
        FBS_RD_WAIT: begin
          rsp_valid <= 1'b1;
          rsp_last <= 1'b1;
          rsp_data <= core_rd_data;
        end
        FBS_GREAD: begin
          rsp_valid <= 1'b1;
          rsp_last <= (gr_idx == fbs_pkg::GR_IDX_LAST);
          rsp_data <= gr_word[gr_idx];
        end
        FBS_IDLE: begin
          if (is_write) begin
            rsp_valid <= 1'b1;
            rsp_last <= 1'b1;
            rsp_err <= !wr_ok;
          end else if (is_read && !slow_read) begin
            rsp_valid <= 1'b1;
            rsp_last <= 1'b1;
            if (cls == fbs_pkg::FBS_CLS_CMD) begin
              rsp_data <= cmd_reg[cmd_idx];
            end else if (req_code == fbs_pkg::CODE_BCAST_SRC) begin
              rsp_data <= broadcast_source_node;
            end else if (cls == fbs_pkg::FBS_CLS_SPECIAL) begin
              rsp_data <= fbs_pkg::SPECIAL_RD_VAL;
            end else begin
              rsp_err <= 1'b1;
            end
          end else if (is_gread && !gread_ok) begin
            rsp_valid <= 1'b1;
            rsp_last <= 1'b1;
            rsp_err <= 1'b1;
          end else if (take && !is_read && !is_gwrite && !is_gread) begin
            rsp_valid <= 1'b1;
            rsp_last <= 1'b1;
            rsp_err <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // fbs_slave

// *** bench/fbs_slave_props.sv ***
`timescale 1ns/100ps
module fbs_slave_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [15:0] req_op,
  input wire logic [7:0] req_src,
  input wire logic [15:0] req_code,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_count,
  input wire logic [15:0] req_gw1,
  input wire logic global_read_switch,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic rsp_last,
  input wire logic [15:0] run_cmd,
  input wire logic [15:0] broadcast_source_node,
  input wire logic params_pending,
  input wire logic activate_pulse,
  input wire logic save_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire tk = req_valid && req_ready;
  wire w1 = tk && req_op == 16'h0001;
  wire bc = tk && req_op == 16'h0005;
  wire gr = tk && req_op == 16'h0006;
  wire src_ok = broadcast_source_node != 16'h0000 &&
    req_src == broadcast_source_node[7:0];
  a_write_run_ack: assert property (
    w1 && req_code == 16'h0001 |-> ##1 rsp_valid && !rsp_err && rsp_last)
    else $error("write to run register not acknowledged");
  a_run_cmd_load: assert property (
    w1 && req_code == 16'h0001 |-> ##2 run_cmd == $past(req_wdata, 2))
    else $error("run register copy not loaded");
  a_monitor_ro: assert property (
    w1 && req_code inside {[16'hf000:16'hf00f]} |-> ##1 rsp_valid && rsp_err)
    else $error("monitor write not refused");
  a_bcast_reject: assert property (
    bc && !src_ok |-> ##2 $stable(run_cmd))
    else $error("broadcast from wrong source changed run register");
  a_bcast_run: assert property (
    bc && src_ok && req_wdata == 16'h0001 && req_count >= 8'h02
    |-> ##2 run_cmd == $past(req_gw1, 2))
    else $error("broadcast run word not taken");
  a_bcast_badsel: assert property (
    bc && (req_wdata == 16'h0000 || req_wdata > 16'h0003)
    |-> ##2 $stable(run_cmd))
    else $error("bad selector changed run register");
  a_gread_off: assert property (
    gr && !global_read_switch |-> ##1 rsp_valid && rsp_err)
    else $error("global read answered while disabled");
  a_gread_end: assert property (
    gr && global_read_switch |-> ##9 rsp_valid && rsp_last && !rsp_err)
    else $error("global read eighth word missing");
  a_gread_busy: assert property (
    gr && global_read_switch |-> ##1 !req_ready[*8])
    else $error("request taken during global read");
  a_save_cmd: assert property (
    w1 && req_code == 16'hfffd && req_wdata == 16'h0000
    |-> ##1 save_pulse && activate_pulse && !params_pending)
    else $error("save command not signalled");
endmodule // fbs_slave_props

bind fbs_slave fbs_slave_props fbs_slave_props_i (.*);

// *** bench/fbs_core_model.sv ***
`timescale 1ns/100ps
module fbs_core_model (
  input wire logic [15:0] core_rd_code,
  output logic [15:0] core_rd_data
);
  // each data code holds its own 16-bit pattern
  assign core_rd_data = core_rd_code ^ 16'ha5c3;
endmodule // fbs_core_model

// *** bench/fbs_slave_tb.sv ***
`timescale 1ns/100ps
module fbs_slave_tb;
  logic mclk = 0, rst_n = 0, req_valid = 0, global_read_switch = 0;
  logic [15:0] req_op = 0, req_code = 0, req_wdata = 0;
  logic [15:0] req_gw1 = 0, req_gw2 = 0;
  logic [7:0] req_src = 0, req_count = 0;
  logic req_ready, rsp_valid, rsp_err, rsp_last, params_pending;
  logic [15:0] rsp_data, run_cmd, freq_ref, broadcast_source_node;
  logic [15:0] core_rd_code, core_rd_data, d;
  logic param_wr_valid, activate_pulse, save_pulse;
  logic [15:0] param_wr_code, param_wr_data;
  logic [15:0] mon [7] = '{default: 16'h0000};
  logic [15:0] cm [16];
  logic [15:0] mb;
  logic [15:0] codes [15] = '{16'h0001, 16'h0002, 16'h000f, 16'h0010,
    16'h0100, 16'h050d, 16'h0126, 16'h0020, 16'h0097, 16'hf005,
    16'hf10a, 16'hf00f, 16'hf201, 16'hffdd, 16'hf200};
  // source node, selector, word count
  logic [23:0] bsel [8] = '{24'h2a0303, 24'h290303, 24'h290102,
    24'h290202, 24'h290302, 24'h290403, 24'h290002, 24'h290103};
  int n_mismatch = 0, checked = 0, cyc = 0;

  fbs_slave fbs_slave_i (.*,
    .mon_out_freq(mon[0]), .mon_out_current(mon[1]),
    .mon_bus_volt(mon[2]), .mon_drive_status(mon[3]),
    .mon_fault1(mon[4]), .mon_fault2(mon[5]), .mon_fault3(mon[6]));
  fbs_core_model fbs_core_model_i (.core_rd_code(core_rd_code),
    .core_rd_data(core_rd_data));

  initial forever #20 mclk = ~mclk;

  task automatic give_verdict();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [17:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int cls(input logic [15:0] c);
    cls = 0;
    if (c >= fbs_pkg::CMD_LO && c <= fbs_pkg::CMD_HI) cls = 1;
    for (int i = 0; i < fbs_pkg::PARAM_RANGES; i++)
      if (c >= fbs_pkg::PARAM_LO[i] && c <= fbs_pkg::PARAM_HI[i]) cls = 2;
    for (int i = 0; i < fbs_pkg::MON_RANGES; i++)
      if (c >= fbs_pkg::MON_LO[i] && c <= fbs_pkg::MON_HI[i]) cls = 3;
    if (c inside {16'hf200, 16'hf201, 16'hffdd, 16'hfffd}) cls = 4;
  endfunction

  task automatic issue(input logic [15:0] op, code, wd,
    input logic [7:0] src = 0, cnt = 0, input logic [15:0] g1 = 0, g2 = 0);
    logic [16:0] e [$];
    int c;
    int k;
    logic [2:0] pe;
    k = cls(code);
    pe = '0;
    if (op == 16'h0001) begin
      // parameter pulse, activate, save
      pe = {k == 2, wd == 0 && code inside {16'hffdd, 16'hfffd},
        wd == 0 && code == 16'hfffd};
      if (k == 1) cm[code[3:0]] = wd;
      if (code == 16'hf200 && wd <= 16'h0040) mb = wd;
      e.push_back((k == 1 || k == 2 || (k == 4 &&
        !(code == 16'hf200 && wd > 16'h0040))) ? 17'h0 : 17'h10000);
    end else if (op == 16'h0002) begin
      e.push_back(k == 0 ? 17'h10000 : k == 1 ? {1'b0, cm[code[3:0]]} :
        k == 4 ? {1'b0, code == 16'hf200 ? mb : 16'h0000} :
        {1'b0, code ^ 16'ha5c3});
    end else if (op == 16'h0005) begin
      if (mb != 0 && src == mb[7:0]) begin
        if (wd == 3 && cnt == 3) cm[1] = g1;
        if (wd == 3 && cnt == 3) cm[2] = g2;
        if (wd == 1 && cnt >= 2) cm[1] = g1;
        if (wd == 2 && cnt >= 2) cm[2] = g1;
      end
    end else if (op == 16'h0006 && global_read_switch) begin
      e.push_back({1'b0, cm[1]});
      for (int i = 0; i < 7; i++) e.push_back({1'b0, mon[i]});
    end else e.push_back(17'h10000);
    @(negedge mclk);
    req_valid = 1;
    req_op = op;
    req_code = code;
    req_wdata = wd;
    // one directly addressed node, single port, no routing words
    req_src = src;
    req_count = cnt;
    req_gw1 = g1;
    req_gw2 = g2;
    c = 0;
    while (req_ready !== 1'b1 && c < 20) begin
      @(negedge mclk);
      c++;
    end
    @(negedge mclk);
    req_valid = 0;
    cmp({param_wr_valid, activate_pulse, save_pulse}, pe);
    if (pe[2]) cmp(param_wr_code, code);
    if (pe[2]) cmp(param_wr_data, wd);
    foreach (e[j]) begin
      c = 0;
      while (rsp_valid !== 1'b1 && c < 4) begin
        @(negedge mclk);
        c++;
      end
      cmp({rsp_valid, rsp_err, rsp_data}, {1'b1, e[j]});
      cmp(18'(rsp_last), 18'(j == e.size() - 1));
      @(negedge mclk);
    end
    @(negedge mclk);
    cmp(run_cmd, cm[1]);
    cmp(freq_ref, cm[2]);
    cmp(broadcast_source_node, mb);
  endtask

  task automatic do_reset();
    rst_n = 0;
    repeat (4) @(negedge mclk);
    cmp({run_cmd, req_ready, rsp_valid}, 0);
    cmp({broadcast_source_node, params_pending}, 0);
    foreach (cm[i]) cm[i] = 0;
    mb = 0;
    rst_n = 1;
  endtask

  initial begin
    void'($urandom(32'h08a19c0b));
    foreach (mon[i]) mon[i] = $urandom;
    do_reset();
    foreach (codes[i]) begin
      d = $urandom;
      issue(16'h0001, codes[i], d);
      issue(16'h0002, codes[i], 0);
    end
    issue(16'h0003, 16'h0001, 0);
    issue(16'h0001, 16'h0280, d);
    cmp(params_pending, 1);
    issue(16'h0001, 16'hffdd, 0);
    cmp(params_pending, 0);
    issue(16'h0001, 16'h0300, d);
    issue(16'h0001, 16'hfffd, 0);
    cmp(params_pending, 0);
    issue(16'h0001, 16'hf200, 0);
    issue(16'h0005, 0, 3, 0, 3, $urandom, $urandom);
    issue(16'h0001, 16'hf200, 16'h0041);
    issue(16'h0001, 16'hf200, 16'h0029);
    foreach (bsel[i])
      issue(16'h0005, 0, bsel[i][15:8], bsel[i][23:16], bsel[i][7:0],
        $urandom, $urandom);
    issue(16'h0001, 16'hf200, 16'h0040);
    issue(16'h0005, 0, 3, 8'h40, 3, $urandom, $urandom);
    issue(16'h0006, 0, 0);
    global_read_switch = 1;
    foreach (mon[i]) mon[i] = $urandom;
    issue(16'h0006, 0, 0);
    issue(16'h0002, 16'hf006, 0);
    do_reset();
    issue(16'h0002, 16'h0001, 0);
    give_verdict();
  end
endmodule // fbs_slave_tb
